// ### include/tfp_map.vh
`ifndef TFP_MAP_VH
`define TFP_MAP_VH
// --------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------
`define TFP_CTRL_ADDR      12'h000
`define TFP_LIMIT_ADDR     12'h004
`define TFP_STATUS_ADDR    12'h008
// --------------------------------------------------------------------
// Control and status fields
// --------------------------------------------------------------------
`define TFP_CTRL_EN_BIT    0
`define TFP_CTRL_TS_BIT    1
`define TFP_CTRL_FMT_LSB   4
`define TFP_CTRL_FMT_MSB   7
`define TFP_CTRL_ABS_BIT   8
`define TFP_CTRL_TF_LSB    9
`define TFP_CTRL_TF_MSB    10
`define TFP_STATUS_BUSY    16
// --------------------------------------------------------------------
// Reset values and limits
// --------------------------------------------------------------------
`define TFP_CTRL_RESET     11'h000
`define TFP_LIMIT_RESET    16'h0800
`define TFP_FMT_MAX        4'h8
// --------------------------------------------------------------------
// Channel word fields
// --------------------------------------------------------------------
`define TFP_CSW_TS_BIT     31
`define TFP_CSW_FMT_LSB    27
`define TFP_CSW_FMT_MSB    30
// --------------------------------------------------------------------
// Word counts
// --------------------------------------------------------------------
`define TFP_CSW_WORDS      17'h00002
`define TFP_TS_WORDS       17'h00004
`define TFP_HDR_WORDS      17'h00002
`endif

// ### rtl/tfp_time_tag.v
`timescale 1ns/100ps
`include "tfp_map.vh"
module tfp_time_tag (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        capture,
	input  wire        abs_sel,
	input  wire [47:0] rel_time,
	input  wire [63:0] abs_time,
	input  wire [1:0]  word_sel,
	output wire [15:0] word
);
	reg [63:0] tag;
	// --------------------------------------------------------------------
	// Capture at first data bit
	// --------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag <= 64'h0000000000000000;
		end else if (capture) begin
			if (abs_sel)
				tag <= abs_time;
			else
				tag <= {16'h0000, rel_time};
		end
	end
	// Low long word first, each low half first
	assign word = (word_sel == 2'h0) ? tag[15:0] :
	              (word_sel == 2'h1) ? tag[31:16] :
	              (word_sel == 2'h2) ? tag[47:32] : tag[63:48];
endmodule // tfp_time_tag

// ### rtl/tfp_framer.v
`timescale 1ns/100ps
`include "tfp_map.vh"
// Functional notes
// - A message is never split across packets; a packet closes only between messages and opens with a whole message.
// - The channel word opens each packet as two words, low half then high half.
// - Channel word bit 31 is one when per-message time tags are present and zero otherwise.
// - Channel word bits 30-27 hold the format code 0 to 8; codes 9 to 15 are never emitted.
// - Channel word bits 26-0 carry nothing.
// - With tags enabled a tag precedes every message; with tags disabled no tag words appear.
// - A tag is 8 bytes, low long word then high long word, each low half first.
// - In relative mode the tag is the 48-bit counter at the first data bit with the top 16 bits zero.
// - In absolute mode the tag is absolute time at the first data bit in the selected time format.
// - Each message is preceded, after its optional tag, by a 4-byte length header.
// - Header bits 15-0 give the message byte length and bits 31-16 carry nothing.
// - Bytes pack two per word, first byte low, with a filler in the high half after an odd count.
module tfp_framer (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [47:0] rel_time,
	input  wire [63:0] abs_time,
	output wire [1:0]  time_format,
	input  wire        flush_req,
	input  wire        msg_valid,
	input  wire [15:0] msg_len,
	output wire        msg_ready,
	input  wire        byte_valid,
	input  wire [7:0]  byte_data,
	output wire        byte_ready,
	output reg         out_valid,
	output reg  [15:0] out_data,
	output reg         out_first,
	input  wire        out_ready,
	output reg         pkt_close
);
	// --------------------------------------------------------------------
	// States
	// --------------------------------------------------------------------
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_CSW  = 5'h02;
	localparam [4:0] S_TS   = 5'h04;
	localparam [4:0] S_HDR  = 5'h08;
	localparam [4:0] S_DATA = 5'h10;

	reg  [10:0] ctrl;
	reg  [15:0] limit;
	reg  [15:0] pkt_count;
	reg  [4:0]  state;
	reg  [1:0]  idx;
	reg         pkt_open;
	reg         pkt_ts;
	reg  [3:0]  pkt_fmt;
	reg  [16:0] used;
	reg  [15:0] len;
	reg  [15:0] rem;
	reg         have_lo;
	reg  [7:0]  lo_byte;
	wire        adv;
	wire        s_idle;
	wire        s_data;
	wire [16:0] needed;
	wire        no_fit;
	wire        take_msg;
	wire        take_byte;
	wire        byte_emits;
	wire [15:0] tag_word;
	wire [31:0] csw;
	wire [31:0] hdr;
	wire        wr;
	wire        wr_ctrl;
	wire        wr_limit;
	wire        fmt_ok;
	wire        rd_hit;
	wire        rd_setup;
	wire        busy;
	wire        close_pkt;
	wire [15:0] csw_word;
	wire [15:0] hdr_word;
	reg  [31:0] next_prdata;

	// --------------------------------------------------------------------
	// APB slave
	// --------------------------------------------------------------------
	assign pready      = 1'b1;
	assign wr          = psel && penable && pwrite;
	assign wr_ctrl     = wr && (paddr == `TFP_CTRL_ADDR);
	assign wr_limit    = wr && (paddr == `TFP_LIMIT_ADDR);
	assign rd_setup    = psel && !penable && !pwrite;
	assign rd_hit      = (paddr == `TFP_CTRL_ADDR) || (paddr == `TFP_LIMIT_ADDR) || (paddr == `TFP_STATUS_ADDR);
	assign pslverr     = psel && penable && !rd_hit;
	assign time_format = ctrl[`TFP_CTRL_TF_MSB:`TFP_CTRL_TF_LSB];
	// Reserved format codes never reach a channel word
	assign fmt_ok      = (pwdata[`TFP_CTRL_FMT_MSB:`TFP_CTRL_FMT_LSB] <= `TFP_FMT_MAX);

	// --------------------------------------------------------------------
	// Register writes
	// --------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl  <= `TFP_CTRL_RESET;
			limit <= `TFP_LIMIT_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl[`TFP_CTRL_EN_BIT]  <= pwdata[`TFP_CTRL_EN_BIT];
				ctrl[`TFP_CTRL_TS_BIT]  <= pwdata[`TFP_CTRL_TS_BIT];
				ctrl[`TFP_CTRL_ABS_BIT] <= pwdata[`TFP_CTRL_ABS_BIT];
				ctrl[`TFP_CTRL_TF_MSB:`TFP_CTRL_TF_LSB] <= pwdata[`TFP_CTRL_TF_MSB:`TFP_CTRL_TF_LSB];
				if (fmt_ok)
					ctrl[`TFP_CTRL_FMT_MSB:`TFP_CTRL_FMT_LSB] <= pwdata[`TFP_CTRL_FMT_MSB:`TFP_CTRL_FMT_LSB];
			end
			if (wr_limit)
				limit <= pwdata[15:0];
		end
	end

	// --------------------------------------------------------------------
	// Read data, captured at the end of the setup phase
	// --------------------------------------------------------------------
	assign busy = !s_idle || pkt_open;

	always @* begin
		next_prdata = 32'h00000000;
		case (paddr)
			`TFP_CTRL_ADDR:   next_prdata = {21'h000000, ctrl};
			`TFP_LIMIT_ADDR:  next_prdata = {16'h0000, limit};
			`TFP_STATUS_ADDR: next_prdata = {15'h0000, busy, pkt_count};
			default:          next_prdata = 32'h00000000;
		endcase
	end

	// Read data stands through the access phase and is zero otherwise
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end else begin
			prdata <= 32'h00000000;
		end
	end

	// --------------------------------------------------------------------
	// Packet fit check
	// --------------------------------------------------------------------
	assign s_idle = (state == S_IDLE);
	assign s_data = (state == S_DATA);
	assign adv    = !out_valid || out_ready;
	assign needed = (ctrl[`TFP_CTRL_TS_BIT] ? `TFP_TS_WORDS : 17'h00000) + `TFP_HDR_WORDS
	                + {2'b00, msg_len[15:1]} + {16'h0000, msg_len[0]};
	// A packet that already holds a message closes rather than take one that overflows it
	assign no_fit   = pkt_open && (used > `TFP_CSW_WORDS) && ((used + needed) > {1'b0, limit});
	assign msg_ready = s_idle && adv && ctrl[`TFP_CTRL_EN_BIT] && !flush_req && !no_fit;
	assign take_msg  = msg_ready && msg_valid;

	// --------------------------------------------------------------------
	// Packet close
	// --------------------------------------------------------------------
	// A full or flushed packet closes only between messages
	assign close_pkt = s_idle && adv && pkt_open && (flush_req || (msg_valid && no_fit));

	// --------------------------------------------------------------------
	// Byte packing
	// --------------------------------------------------------------------
	assign byte_emits = have_lo || (rem == 16'h0001);
	assign byte_ready = s_data && (rem != 16'h0000) && (!byte_emits || adv);
	assign take_byte  = byte_ready && byte_valid;

	// --------------------------------------------------------------------
	// Channel word and length header
	// --------------------------------------------------------------------
	assign csw = {pkt_ts, pkt_fmt, 27'h0000000};
	assign hdr = {16'h0000, len};

	// --------------------------------------------------------------------
	// Low half first within each two-word field
	// --------------------------------------------------------------------
	assign csw_word = (idx == 2'h0) ? csw[15:0] : csw[31:16];
	assign hdr_word = (idx == 2'h0) ? hdr[15:0] : hdr[31:16];

	tfp_time_tag tfp_time_tag_i (
		.pclk     (pclk),
		.presetn  (presetn),
		.capture  (take_msg),
		.abs_sel  (ctrl[`TFP_CTRL_ABS_BIT]),
		.rel_time (rel_time),
		.abs_time (abs_time),
		.word_sel (idx),
		.word     (tag_word)
	);

	// --------------------------------------------------------------------
	// Framing sequencer
	// --------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= S_IDLE;
			idx       <= 2'h0;
			pkt_open  <= 1'b0;
			pkt_ts    <= 1'b0;
			pkt_fmt   <= 4'h0;
			used      <= 17'h00000;
			len       <= 16'h0000;
			rem       <= 16'h0000;
			have_lo   <= 1'b0;
			lo_byte   <= 8'h00;
			pkt_count <= 16'h0000;
			out_valid <= 1'b0;
			out_data  <= 16'h0000;
			out_first <= 1'b0;
			pkt_close <= 1'b0;
		end else begin
			pkt_close <= 1'b0;
			if (out_valid && out_ready)
				out_valid <= 1'b0;
			case (state)
				S_IDLE: begin
					if (close_pkt) begin
						pkt_open  <= 1'b0;
						pkt_close <= 1'b1;
						pkt_count <= pkt_count + 16'h0001;
					end else if (take_msg) begin
						len     <= msg_len;
						rem     <= msg_len;
						have_lo <= 1'b0;
						idx     <= 2'h0;
						if (!pkt_open) begin
							pkt_open <= 1'b1;
							pkt_ts   <= ctrl[`TFP_CTRL_TS_BIT];
							pkt_fmt  <= ctrl[`TFP_CTRL_FMT_MSB:`TFP_CTRL_FMT_LSB];
							used     <= 17'h00000;
							state    <= S_CSW;
						end else if (pkt_ts) begin
							state <= S_TS;
						end else begin
							state <= S_HDR;
						end
					end
				end
				S_CSW: begin
					if (adv) begin
						out_valid <= 1'b1;
						out_first <= (idx == 2'h0);
						out_data  <= csw_word;
						used      <= used + 17'h00001;
						idx       <= (idx == 2'h0) ? 2'h1 : 2'h0;
						if (idx != 2'h0)
							state <= pkt_ts ? S_TS : S_HDR;
					end
				end
				S_TS: begin
					if (adv) begin
						out_valid <= 1'b1;
						out_first <= 1'b0;
						out_data  <= tag_word;
						used      <= used + 17'h00001;
						idx       <= idx + 2'h1;
						if (idx == 2'h3)
							state <= S_HDR;
					end
				end
				S_HDR: begin
					if (adv) begin
						out_valid <= 1'b1;
						out_first <= 1'b0;
						out_data  <= hdr_word;
						used      <= used + 17'h00001;
						idx       <= (idx == 2'h0) ? 2'h1 : 2'h0;
						if (idx != 2'h0)
							state <= S_DATA;
					end
				end
				S_DATA: begin
					if (rem == 16'h0000) begin
						state <= S_IDLE;
					end else if (take_byte) begin
						rem <= rem - 16'h0001;
						if (byte_emits) begin
							out_valid <= 1'b1;
							out_first <= 1'b0;
							out_data  <= have_lo ? {byte_data, lo_byte} : {8'h00, byte_data};
							used      <= used + 17'h00001;
							have_lo   <= 1'b0;
						end else begin
							lo_byte <= byte_data;
							have_lo <= 1'b1;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule // tfp_framer

// ### verification/tfp_framer_monitor.sv
`timescale 1ns/100ps
`include "tfp_map.vh"
module tfp_framer_monitor (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        msg_valid,
	input wire        msg_ready,
	input wire        out_valid,
	input wire [15:0] out_data,
	input wire        out_first,
	input wire        out_ready,
	input wire        pkt_close
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire hit = paddr == `TFP_CTRL_ADDR || paddr == `TFP_LIMIT_ADDR || paddr == `TFP_STATUS_ADDR;
	property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_first); endproperty
	a_hold: assert property (p_hold) else $error("word changed while stalled");
	property p_csw_lo; out_valid && out_first |-> out_data == 16'h0000; endproperty
	a_csw_lo: assert property (p_csw_lo) else $error("channel word low half not zero");
	property p_csw_hi; out_valid && out_first && out_ready |=> out_valid && !out_first && out_data[10:0] == 11'h000
		&& out_data[14:11] <= 4'h8; endproperty
	a_csw_hi: assert property (p_csw_hi) else $error("bad channel word high half");
	property p_close; pkt_close |=> !pkt_close; endproperty
	a_close: assert property (p_close) else $error("close pulse too long");
	property p_take; msg_valid && msg_ready |=> !msg_ready ##1 out_valid; endproperty
	a_take: assert property (p_take) else $error("no word after message taken");
	property p_err; psel && penable && !hit |-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok; psel && penable && hit |-> !pslverr && pready; endproperty
	a_ok: assert property (p_ok) else $error("mapped access refused");
	property p_rd; !(psel && !pwrite) |-> prdata == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data outside read");
endmodule // tfp_framer_monitor
bind tfp_framer tfp_framer_monitor tfp_framer_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .msg_valid, .msg_ready, .out_valid, .out_data, .out_first, .out_ready, .pkt_close);

// ### verification/tfp_peer.sv
`timescale 1ns/100ps
// ----
// Message source and word sink
// ----
module tfp_peer (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         stall,
	input  wire         msg_ready,
	input  wire         byte_ready,
	input  wire         out_valid,
	input  wire  [15:0] out_data,
	input  wire         out_first,
	input  wire  [47:0] rel_time,
	output logic        msg_valid = 0,
	output logic [15:0] msg_len = 0,
	output logic        byte_valid = 0,
	output logic [7:0]  byte_data = 0,
	output logic        out_ready = 0
);
	logic [15:0] lq[$];
	logic [7:0]  bq[$];
	logic [47:0] tq[$];
	logic [16:0] got[$];
	always @(posedge pclk) begin
		if (msg_valid && msg_ready) begin
			tq.push_back(rel_time);
			void'(lq.pop_front());
		end
		if (byte_valid && byte_ready)
			void'(bq.pop_front());
		if (out_valid && out_ready)
			got.push_back({out_first, out_data});
		msg_valid <= presetn && lq.size() > 0;
		msg_len <= lq.size() > 0 ? lq[0] : ~msg_len;
		byte_valid <= presetn && bq.size() > 0;
		byte_data <= bq.size() > 0 ? bq[0] : ~byte_data;
		out_ready <= presetn && (!stall || $urandom % 3 != 0);
	end
endmodule // tfp_peer

// ### verification/tfp_framer_tb.sv
`timescale 1ns/100ps
`include "tfp_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tfp_framer_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flush_req = 0, stall = 0, se, ts, ab;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, msg_valid, msg_ready, byte_valid, byte_ready, out_valid, out_first, out_ready;
	logic        pkt_close;
	logic [47:0] rel_time = 0;
	logic [63:0] abs_time = 0, t;
	logic [1:0]  time_format, tf;
	logic [15:0] msg_len, out_data, lim;
	logic [7:0]  byte_data, b1, b2;
	logic [15:0] L[$];
	logic [7:0]  B[$];
	logic [16:0] exq[$];
	int          err_count = 0, check_count = 0, npk = 0, u, n, need;
	always #4 pclk = ~pclk;
	always @(posedge pclk) rel_time <= rel_time + 48'h1;
	tfp_framer tfp_framer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rel_time, .abs_time, .time_format, .flush_req, .msg_valid, .msg_len, .msg_ready, .byte_valid,
		.byte_data, .byte_ready, .out_valid, .out_data, .out_first, .out_ready, .pkt_close);
	tfp_peer tfp_peer_i (.pclk, .presetn, .stall, .msg_ready, .byte_ready, .out_valid, .out_data, .out_first,
		.rel_time, .msg_valid, .msg_len, .byte_valid, .byte_data, .out_ready);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic int need_words(input int n, input logic ts);
		return (ts ? 4 : 0) + 2 + (n + 1) / 2;
	endfunction
	initial begin
		#400000;
		err_count++;
		complete_run;
	end
	initial begin
		void'($urandom(61));
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(0, `TFP_LIMIT_ADDR, 0);
		`CHK(rd, 32'h0000_0800)
		apb(0, 12'h00c, 0);
		`CHK({se, rd}, 33'h1_0000_0000)
		apb(1, `TFP_CTRL_ADDR, 32'h0000_0091);
		apb(0, `TFP_CTRL_ADDR, 0);
		`CHK(rd, 32'h0000_0001)
		$display("test registers done");
		stall <= 1;
		for (int f = 0; f <= 8; f++) begin
			ts = f[0];
			ab = f[1];
			tf = 2'($urandom);
			lim = 16'(6 + $urandom % 10);
			abs_time <= {$urandom, $urandom};
			apb(1, `TFP_LIMIT_ADDR, {16'h0, lim});
			apb(1, `TFP_CTRL_ADDR, {21'h0, tf, ab, 4'(f), 2'b0, ts, 1'b1});
			@(posedge pclk);
			`CHK(time_format, tf)
			for (int m = 0; m < 3; m++) begin
				L.push_back(16'($urandom % 6));
				for (int i = 0; i < L[m]; i++) B.push_back(8'($urandom));
			end
			foreach (B[i]) tfp_peer_i.bq.push_back(B[i]);
			foreach (L[i]) tfp_peer_i.lq.push_back(L[i]);
			while (tfp_peer_i.lq.size() || tfp_peer_i.bq.size()) @(posedge pclk);
			flush_req <= 1;
			do @(posedge pclk); while (pkt_close !== 1'b1);
			flush_req <= 0;
			repeat (2) @(posedge pclk);
			u = 0;
			foreach (L[k]) begin
				n = L[k];
				t = {16'h0, tfp_peer_i.tq.pop_front()};
				if (ab) t = abs_time;
				need = need_words(n, ts);
				if (u > 2 && u + need > lim) u = 0;
				if (u == 0) begin
					exq.push_back(17'h1_0000);
					exq.push_back({1'b0, ts, 4'(f), 11'h0});
					u = 2;
					npk++;
				end
				u += need;
				for (int i = 0; i < 4 && ts; i++) exq.push_back({1'b0, t[16*i +: 16]});
				exq.push_back({1'b0, L[k]});
				exq.push_back(17'h0);
				for (int i = 0; i < n; i += 2) begin
					b1 = B.pop_front();
					b2 = i + 1 < n ? B.pop_front() : 8'h00;
					exq.push_back({1'b0, b2, b1});
				end
			end
			`CHK(tfp_peer_i.got.size(), exq.size())
			foreach (exq[i]) `CHK(tfp_peer_i.got[i], exq[i])
			tfp_peer_i.got.delete();
			exq.delete();
			L.delete();
			$display("test format %0d done", f);
		end
		apb(0, `TFP_STATUS_ADDR, 0);
		`CHK(rd[16:0], {1'b0, 16'(npk)})
		complete_run;
	end
endmodule // tfp_framer_tb
